// >>> src/sgrxeb_top.sv
// sgmii receive elastic buffer with staging fifo and clock enables
// assumes link clock and symbols arrive as pins sampled by mclk
`timescale 1ns/1ps

// small staging fifo between elastic buffer and the pcs input
module sgrxeb_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,      // system clock
    input  wire logic             sys_rst,   // async reset, high
    input  wire logic             in_valid,  // write request
    output logic                  in_ready,  // space available
    input  wire logic [WIDTH-1:0] in_data,   // write word
    output logic                  out_valid, // word available
    input  wire logic             out_ready, // drain accepts
    output logic      [WIDTH-1:0] out_data   // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_reg];

    // storage, no reset needed on the data words
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // sgrxeb_fifo

// Operation
// - with the logic buffer chosen, the transceiver buffer is bypassed.
// - one memory array, twice the transceiver buffer's entry count.
// - transceiver buffer is 64 entries, so this one holds 128.
// - in interframe gap, idles deleted to bring occupancy back to half.
// - logic buffer is the default selection.
// - tolerate 200 ppm, one entry drift per 5000 periods.
// - cope with byte repetition of 10 and 100 at lower rates.
// - at 10 Mb/s keep at least 31 entries margin both sides.
// - 1522-byte frames pass without under or overflow at all rates.
// - same oscillator both sides keeps occupancy constant.
// - 50 ppm sources need only 16 entries margin each side.
// - transceiver reference 125 MHz, its output clock 62.5 MHz.
// - first manager output, 125 MHz, clocks core logic and read side.
// - second output, 62.5 MHz, fed back to both transmit user clocks.
// - recovered receive clock times writes into the buffer.
// - buffer sits between transceiver output and pcs core input.
// - reading begins only once the buffer is half full.
// - core side always runs at 125 MHz, rates shown by repetition.
module sgrxeb_top #(
    parameter logic USE_LOGIC_BUFFER = sgrxeb_pkg::USE_LOGIC_BUFFER_RST
) (
    input  wire logic                    mclk,        // 200 MHz clock
    input  wire logic                    sys_rst,     // async reset, high
    input  wire logic                    rx_link_clk, // recovered clock pin
    input  wire sgrxeb_pkg::sgrxeb_sym_t rx_link_sym, // recovered symbol
    output sgrxeb_pkg::sgrxeb_sym_t      pcs_sym,     // symbol to pcs
    output logic                         pcs_valid,   // pcs_sym valid
    input  wire logic                    pcs_ready,   // pcs accepts
    output logic                         core_clock_125, // 125 MHz enable
    output logic                transceiver_user_clock_62p5, // 62.5 enable
    output logic           transceiver_user_tx_clock_second, // same, tx2
    output logic                         xcvr_buffer_bypass, // bypass
    output logic                         eb_overflow,  // write lost
    output logic                         eb_underflow, // read starved
    output logic [sgrxeb_pkg::EB_PW-1:0] eb_occupancy  // read-side fill
);
    localparam int PW = sgrxeb_pkg::EB_PW;
    localparam int AW = sgrxeb_pkg::EB_AW;

    typedef enum logic {SGRXEB_PRIME, SGRXEB_RUN} sgrxeb_state_t;

    function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = g;
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // one array sized by the package
    sgrxeb_pkg::sgrxeb_sym_t mem [sgrxeb_pkg::EB_DEPTH];

    logic [3:0]              acc_reg;
    logic                    ce125_reg;
    logic                    ce62_reg;
    logic                    half_reg;
    logic                    bypass_reg;
    logic [2:0]              lclk_sync_reg;
    sgrxeb_pkg::sgrxeb_sym_t sym_s1_reg;
    sgrxeb_pkg::sgrxeb_sym_t sym_s2_reg;
    logic                    link_edge;
    sgrxeb_pkg::sgrxeb_sym_t prev_reg;
    logic                    prev_vld_reg;
    logic                    w_frame_reg;
    logic [PW-1:0]           wr_bin_reg;
    logic [PW-1:0]           wr_gray_reg;
    logic [PW-1:0]           rd_bin_reg;
    logic [PW-1:0]           rd_gray_reg;
    logic [PW-1:0]           rg_s1_reg;
    logic [PW-1:0]           rg_s2_reg;
    logic [PW-1:0]           wg_s1_reg;
    logic [PW-1:0]           wg_s2_reg;
    logic [PW-1:0]           occ_w;
    logic [PW-1:0]           occ_r;
    logic                    del_set;
    logic                    wr_try;
    logic                    wr_en;
    sgrxeb_state_t           state_reg;
    logic [1:0]              replay_reg;
    logic                    r_frame_reg;
    logic                    last_comma_reg;
    logic                    rd_slot;
    logic                    rd_en;
    logic                    push;
    sgrxeb_pkg::sgrxeb_sym_t push_sym;
    logic                    fifo_in_ready;
    logic [sgrxeb_pkg::SYM_W-1:0] fifo_out;

    // fractional divider gives the 125 MHz core enable
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_reg   <= '0;
            ce125_reg <= 1'b0;
        end else if (acc_reg + sgrxeb_pkg::ACC_STEP
                     >= sgrxeb_pkg::ACC_MOD) begin
            acc_reg   <= acc_reg + sgrxeb_pkg::ACC_STEP - sgrxeb_pkg::ACC_MOD;
            ce125_reg <= 1'b1;
        end else begin
            acc_reg   <= acc_reg + sgrxeb_pkg::ACC_STEP;
            ce125_reg <= 1'b0;
        end
    end

    // every second core enable drives the transceiver user clocks
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            half_reg <= 1'b0;
            ce62_reg <= 1'b0;
        end else begin
            ce62_reg <= ce125_reg && half_reg;
            if (ce125_reg) begin
                half_reg <= ~half_reg;
            end
        end
    end

    assign core_clock_125                   = ce125_reg;
    assign transceiver_user_clock_62p5      = ce62_reg;
    assign transceiver_user_tx_clock_second = ce62_reg;

    // bypass follows the build choice, default logic buffer
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bypass_reg <= sgrxeb_pkg::USE_LOGIC_BUFFER_RST;
        end else begin
            bypass_reg <= USE_LOGIC_BUFFER;
        end
    end
    assign xcvr_buffer_bypass = bypass_reg;

    // link clock and symbols pass two flops, then edge found
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lclk_sync_reg <= '0;
            sym_s1_reg    <= '0;
            sym_s2_reg    <= '0;
        end else begin
            lclk_sync_reg <= {lclk_sync_reg[1:0], rx_link_clk};
            sym_s1_reg    <= rx_link_sym;
            sym_s2_reg    <= sym_s1_reg;
        end
    end
    assign link_edge = lclk_sync_reg[1] && !lclk_sync_reg[2];

    // gray pointers, each crossing through two flops
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rg_s1_reg <= '0;
            rg_s2_reg <= '0;
            wg_s1_reg <= '0;
            wg_s2_reg <= '0;
        end else begin
            rg_s1_reg <= rd_gray_reg;
            rg_s2_reg <= rg_s1_reg;
            wg_s1_reg <= wr_gray_reg;
            wg_s2_reg <= wg_s1_reg;
        end
    end
    assign occ_w = wr_bin_reg - g2b(rg_s2_reg);
    assign occ_r = g2b(wg_s2_reg) - rd_bin_reg;

    // drop a comma plus idle second pair only outside frames
    assign del_set = link_edge && prev_vld_reg && !w_frame_reg
                     && prev_reg.k && (prev_reg.d == sgrxeb_pkg::K28_5)
                     && !sym_s2_reg.k
                     && ((sym_s2_reg.d == sgrxeb_pkg::D16_2)
                         || (sym_s2_reg.d == sgrxeb_pkg::D5_6))
                     && (occ_w > sgrxeb_pkg::EB_HALF);
    assign wr_try  = link_edge && prev_vld_reg && !del_set;
    // never write into a full buffer
    assign wr_en   = wr_try && (occ_w != sgrxeb_pkg::EB_FULL);

    // one-symbol delay line lets a whole idle pair be judged at once
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_reg     <= '0;
            prev_vld_reg <= 1'b0;
            w_frame_reg  <= 1'b0;
        end else if (link_edge) begin
            prev_reg     <= sym_s2_reg;
            prev_vld_reg <= !del_set;
            if (sym_s2_reg.k && sym_s2_reg.d == sgrxeb_pkg::K27_7) begin
                w_frame_reg <= 1'b1;
            end else if (sym_s2_reg.k
                         && sym_s2_reg.d == sgrxeb_pkg::K29_7) begin
                w_frame_reg <= 1'b0;
            end
        end
    end

    // repeated bytes are plain symbols, any frame length
    // write side, timed by recovered clock edges
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_bin_reg  <= '0;
            wr_gray_reg <= '0;
        end else if (wr_en) begin
            wr_bin_reg  <= wr_bin_reg + 1'b1;
            wr_gray_reg <= (wr_bin_reg + 1'b1) ^ ((wr_bin_reg + 1'b1) >> 1);
        end
    end

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_bin_reg[AW-1:0]] <= prev_reg;
        end
    end

    // overflow pulse when a symbol finds the buffer full
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            eb_overflow <= 1'b0;
        end else begin
            eb_overflow <= wr_try && (occ_w == sgrxeb_pkg::EB_FULL);
        end
    end

    // reads at the 125 MHz rate, stalled by the staging fifo
    assign rd_slot = ce125_reg && fifo_in_ready && state_reg == SGRXEB_RUN;
    assign rd_en   = rd_slot && replay_reg == '0 && occ_r != '0;
    assign push    = rd_slot && (replay_reg != '0 || occ_r != '0);
    always_comb begin
        push_sym = mem[rd_bin_reg[AW-1:0]];
        if (replay_reg == sgrxeb_pkg::REPLAY_SET) begin
            push_sym = '{k: 1'b1, d: sgrxeb_pkg::K28_5};
        end else if (replay_reg != '0) begin
            push_sym = '{k: 1'b0, d: sgrxeb_pkg::D16_2};
        end
    end

    // hold reads until half full; restart priming after underflow
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= SGRXEB_PRIME;
        end else begin
            unique case (state_reg)
                SGRXEB_PRIME: begin
                    if (occ_r >= sgrxeb_pkg::EB_HALF) begin
                        state_reg <= SGRXEB_RUN;
                    end
                end
                SGRXEB_RUN: begin
                    if (rd_slot && replay_reg == '0 && occ_r == '0) begin
                        state_reg <= SGRXEB_PRIME;
                    end
                end
            endcase
        end
    end

    // underflow pulse rather than re-sending stale entries
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            eb_underflow <= 1'b0;
        end else begin
            eb_underflow <= rd_slot && replay_reg == '0 && occ_r == '0;
        end
    end

    // read pointer; gray copy goes to the write side
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_bin_reg  <= '0;
            rd_gray_reg <= '0;
        end else if (rd_en) begin
            rd_bin_reg  <= rd_bin_reg + 1'b1;
            rd_gray_reg <= (rd_bin_reg + 1'b1) ^ ((rd_bin_reg + 1'b1) >> 1);
        end
    end

    // below half, repeat one idle pair in the gap so a slow
    // writer is recovered; at equal rates nothing is added or dropped
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            replay_reg     <= '0;
            r_frame_reg    <= 1'b0;
            last_comma_reg <= 1'b0;
        end else if (push) begin
            if (replay_reg != '0) begin
                replay_reg <= replay_reg - 1'b1;
            end else if (last_comma_reg && !r_frame_reg && !push_sym.k
                         && push_sym.d == sgrxeb_pkg::D16_2
                         && occ_r < sgrxeb_pkg::EB_HALF) begin
                replay_reg <= sgrxeb_pkg::REPLAY_SET;
            end
            last_comma_reg <= push_sym.k && push_sym.d == sgrxeb_pkg::K28_5;
            if (push_sym.k && push_sym.d == sgrxeb_pkg::K27_7) begin
                r_frame_reg <= 1'b1;
            end else if (push_sym.k && push_sym.d == sgrxeb_pkg::K29_7) begin
                r_frame_reg <= 1'b0;
            end
        end
    end

    // occupancy seen by the core side
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            eb_occupancy <= '0;
        end else begin
            eb_occupancy <= occ_r;
        end
    end

    // staging fifo feeds the pcs input; its ready stalls reads
    sgrxeb_fifo #(
        .WIDTH (sgrxeb_pkg::SYM_W),
        .DEPTH (sgrxeb_pkg::OUT_FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_sym),
        .out_valid (pcs_valid),
        .out_ready (pcs_ready),
        .out_data  (fifo_out)
    );
    assign pcs_sym = fifo_out;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    AST_BYPASS_STEADY: assert property (
        ##2 xcvr_buffer_bypass == USE_LOGIC_BUFFER)
        else $error("bypass flag does not follow buffer choice");
    AST_OCC_BOUND: assert property (
        occ_w <= sgrxeb_pkg::EB_FULL && occ_r <= sgrxeb_pkg::EB_FULL)
        else $error("occupancy beyond 128 entries");
    AST_DEL_GAP: assert property (
        del_set |-> !w_frame_reg && prev_reg.d == sgrxeb_pkg::K28_5)
        else $error("deletion inside a frame or not on an idle");
    AST_DEL_HALF: assert property (
        del_set |-> !wr_en ##1 !prev_vld_reg)
        else $error("deleted idle still written");
    AST_OVF_PULSE: assert property (
        (wr_try && occ_w == sgrxeb_pkg::EB_FULL) |-> !wr_en ##1 eb_overflow)
        else $error("full write not refused and flagged");
    AST_PRIME_HOLD: assert property (
        state_reg == SGRXEB_PRIME |-> !push)
        else $error("read while priming to half");
    AST_CE62: assert property (
        ce62_reg |=> !ce62_reg ##1 !ce62_reg)
        else $error("62.5 MHz enable too dense");
    AST_CE125: assert property (
        ce125_reg [*2] |=> !ce125_reg)
        else $error("125 MHz enable above rate");
    AST_GRAY_STEP: assert property (
        $countones(wr_gray_reg ^ $past(wr_gray_reg)) <= 1)
        else $error("gray write pointer moved more than one bit");
    AST_MARGIN_10M: assert property (
        $rose(state_reg == SGRXEB_RUN)
        |-> occ_r >= PW'(sgrxeb_pkg::MARGIN_10M)
            && sgrxeb_pkg::EB_FULL - occ_r >= PW'(sgrxeb_pkg::MARGIN_10M))
        else $error("reading starts without slow-rate margin");
    AST_MARGIN_50PPM: assert property (
        $rose(state_reg == SGRXEB_RUN)
        |-> occ_r >= PW'(sgrxeb_pkg::MARGIN_50PPM)
            && sgrxeb_pkg::EB_FULL - occ_r >= PW'(sgrxeb_pkg::MARGIN_50PPM))
        else $error("reading starts without close-clock margin");

    COV_DELETE: cover property (del_set);
    COV_REPLAY: cover property (replay_reg == sgrxeb_pkg::REPLAY_SET);
    COV_OVERFLOW: cover property (eb_overflow);
    COV_STALL: cover property (pcs_valid && !pcs_ready ##1 !fifo_in_ready);
endmodule // sgrxeb_top

// >>> src/sgrxeb_pkg.sv
// package for the sgmii receive elastic buffer: symbols, sizes, rates
// assumes an 8b10b-decoded symbol stream and a single 200 MHz system clock
package sgrxeb_pkg;

    // one decoded line symbol: control flag plus byte
    typedef struct packed {
        logic       k;
        logic [7:0] d;
    } sgrxeb_sym_t;

    localparam int SYM_W = 9;

    // buffer sizing: twice the transceiver's own buffer
    localparam int XCVR_BUF_DEPTH = 64;
    localparam int EB_DEPTH       = 2 * XCVR_BUF_DEPTH;
    localparam int EB_AW          = 7;
    localparam int EB_PW          = EB_AW + 1;
    localparam logic [EB_PW-1:0] EB_FULL  = 8'h80;
    localparam logic [EB_PW-1:0] EB_HALF  = 8'h40;

    // clock tolerance budget
    localparam int PPM_TOL_TOTAL        = 200;
    localparam int DRIFT_PERIODS_200PPM = 5000;
    localparam int DRIFT_PERIODS_100PPM = 10000;
    localparam int MAX_FRAME_BYTES      = 1522;
    localparam int REPEAT_100M          = 10;
    localparam int REPEAT_10M           = 100;
    localparam int FRAME_CYCLES_10M     = MAX_FRAME_BYTES * REPEAT_10M;
    localparam int MARGIN_10M =
        (FRAME_CYCLES_10M + DRIFT_PERIODS_200PPM - 1) / DRIFT_PERIODS_200PPM;
    localparam int MARGIN_50PPM = 16;

    // code groups used for framing and clock correction
    localparam logic [7:0] K28_5 = 8'hBC;  // comma, first of idle
    localparam logic [7:0] K27_7 = 8'hFB;  // start of packet
    localparam logic [7:0] K29_7 = 8'hFD;  // end of packet
    localparam logic [7:0] D16_2 = 8'h50;  // idle /I2/ second
    localparam logic [7:0] D5_6  = 8'hC5;  // idle /I1/ second

    // rates; core and transceiver user clocks become enables
    localparam int MCLK_KHZ     = 200000;
    localparam int CORE_KHZ     = 125000;
    localparam int XCVR_USR_KHZ = 62500;
    localparam int ACC_UNIT_KHZ = 25000;
    localparam logic [3:0] ACC_STEP = 4'(CORE_KHZ / ACC_UNIT_KHZ);
    localparam logic [3:0] ACC_MOD  = 4'(MCLK_KHZ / ACC_UNIT_KHZ);

    // output staging fifo
    localparam int OUT_FIFO_DEPTH = 8;

    // buffer choice reset value; replay count loaded on an insertion
    localparam logic USE_LOGIC_BUFFER_RST = 1'b1;
    localparam logic [1:0] REPLAY_SET     = 2'h2;

endpackage

// >>> bench/sgrxeb_link_model.sv
// link-side model: recovered clock and symbol pins of the transceiver
// assumes the bench queues whole frames; idle pairs fill every gap
`timescale 1ns/1ps

module sgrxeb_link_model (
    output logic                    rx_link_clk, // recovered clock
    output sgrxeb_pkg::sgrxeb_sym_t rx_link_sym, // symbol on the pins
    output int                      sent         // symbols clocked out
);
    sgrxeb_pkg::sgrxeb_sym_t q[$];
    logic                    alt;

    task automatic put(input logic k, input logic [7:0] d);
        rx_link_clk = 1'b0;
        rx_link_sym = {k, d};
        #62.5;
        rx_link_clk = 1'b1;
        sent++;
        #62.5;
    endtask

    // clock runs free; gaps only ever carry whole idle pairs
    initial begin
        rx_link_clk = 1'b0;
        rx_link_sym = '0;
        sent = 0;
        alt = 1'b0;
        #3.3;
        forever begin
            if (q.size() == 0) begin
                put(1'b1, sgrxeb_pkg::K28_5);
                put(1'b0, alt ? sgrxeb_pkg::D5_6 : sgrxeb_pkg::D16_2);
                alt = ~alt;
            end else begin
                put(q[0].k, q[0].d);
                q.delete(0);
            end
        end
    end
endmodule // sgrxeb_link_model

// >>> bench/sgrxeb_top_tb.sv
// bench for the receive elastic buffer: link model in, pcs sink out
// assumes the link model runs from time zero at 125 ns per symbol
`timescale 1ns/1ps

module sgrxeb_top_tb;
    logic                         mclk;
    logic                         sys_rst;
    logic                         rx_link_clk;
    sgrxeb_pkg::sgrxeb_sym_t      rx_link_sym;
    sgrxeb_pkg::sgrxeb_sym_t      pcs_sym;
    logic                         pcs_valid;
    logic                         pcs_ready;
    logic                         core_clk;
    logic                         usr_clk;
    logic                         usr_clk2;
    logic                         bypass;
    logic                         ovf;
    logic                         unf;
    logic [sgrxeb_pkg::EB_PW-1:0] occ;
    int                           sent;
    int                           mismatches;
    int                           comparisons;
    int                           rdy_mode;
    int                           ovf_seen;
    int                           unf_seen;
    int                           occ_max;
    int                           n0;
    int                           n1;
    int                           n2;
    bit                           chk_en;
    bit                           skip;
    sgrxeb_pkg::sgrxeb_sym_t      exp_q[$];

    // logic buffer kept, 100 Mb/s repetition is exercised
    sgrxeb_top DUT (
        .mclk(mclk), .sys_rst(sys_rst), .rx_link_clk(rx_link_clk),
        .rx_link_sym(rx_link_sym), .pcs_sym(pcs_sym),
        .pcs_valid(pcs_valid), .pcs_ready(pcs_ready),
        .core_clock_125(core_clk), .transceiver_user_clock_62p5(usr_clk),
        .transceiver_user_tx_clock_second(usr_clk2),
        .xcvr_buffer_bypass(bypass), .eb_overflow(ovf),
        .eb_underflow(unf), .eb_occupancy(occ)
    );
    sgrxeb_link_model LINK (
        .rx_link_clk(rx_link_clk), .rx_link_sym(rx_link_sym), .sent(sent)
    );

    task automatic check_sym(input sgrxeb_pkg::sgrxeb_sym_t e, g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic check_val(input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic results();
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // the link model gets the symbol, the scoreboard its note while chk_en is set
    task automatic push(input logic k, input logic [7:0] d);
        LINK.q.push_back({k, d});
        if (chk_en) exp_q.push_back({k, d});
    endtask

    task automatic send_frame(input int len, input int rep);
        logic [7:0] d;
        push(1'b1, sgrxeb_pkg::K27_7);
        for (int i = 0; i < len; i++) begin
            d = 8'($urandom);
            for (int r = 0; r < rep; r++) push(1'b0, d);
        end
        push(1'b1, sgrxeb_pkg::K29_7);
        wait (LINK.q.size() == 0);
    endtask

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // sink: stalled, always ready, or ready one cycle in 25 on average,
    // the link's own symbol rate, so the fill only wanders about half
    always @(posedge mclk) begin
        #1;
        pcs_ready <= rdy_mode == 1
                     || (rdy_mode == 2 && $urandom_range(24) == 0);
    end

    // idle pairs may be dropped or repeated, so only frame symbols count
    always @(posedge mclk) begin
        if (ovf === 1'b1) ovf_seen++;
        if (unf === 1'b1) unf_seen++;
        if (occ > occ_max) occ_max = occ;
        if (pcs_valid === 1'b1 && pcs_ready === 1'b1) begin
            if (skip) skip = 0;
            else if (pcs_sym.k && pcs_sym.d == sgrxeb_pkg::K28_5) skip = 1;
            else if (chk_en && exp_q.size() == 0)
                check_sym(9'h1FF, pcs_sym);
            else if (chk_en)
                check_sym(exp_q.pop_front(), pcs_sym);
        end
    end

    // a run is about 20k cycles; this allows well over twice that
    initial begin
        #300000;
        mismatches++;
        results();
    end

    initial begin
        void'($urandom(32'h20C9));
        sys_rst = 1'b1;
        pcs_ready = 1'b0;
        rdy_mode = 0;
        chk_en = 0;
        repeat (4) @(posedge mclk);
        check_val(1, bypass);
        check_val(0, {pcs_valid, ovf, unf, occ});
        #1 sys_rst = 1'b0;
        // enables: 5 of 8 cycles, 62.5 on every second one; the 801st
        // cycle has no core pulse but catches the late 62.5 pulse
        repeat (801) begin
            @(posedge mclk);
            #2;
            n0 += core_clk === 1'b1;
            n1 += usr_clk === 1'b1;
            n2 += usr_clk2 !== usr_clk;
        end
        check_val(500, n0);
        check_val(250, n1);
        check_val(0, n2);
        check_val(1, bypass);
        for (int i = 0; i < 4000 && pcs_valid !== 1'b1; i++) @(posedge mclk);
        check_val(1, pcs_valid === 1'b1 && sent > 64);
        // stalled sink, idles only: deletion holds the fill near half
        repeat (100) @(posedge rx_link_clk);
        occ_max = 0;
        repeat (100) @(posedge rx_link_clk);
        check_val(1, occ >= 62 && occ_max <= 68);
        check_val(0, ovf_seen);
        // frames through a slow sink, one with tenfold repetition
        chk_en = 1;
        rdy_mode = 2;
        for (int i = 0; i < 6; i++) begin
            send_frame($urandom_range(4, 24), i == 4 ? 10 : 1);
            repeat (16) @(posedge rx_link_clk);
        end
        for (int i = 0; i < 20000 && exp_q.size() > 0; i++) @(posedge mclk);
        check_val(0, exp_q.size());
        check_val(0, ovf_seen + unf_seen);
        // stalled sink, a long frame cannot lose idles: fills up
        chk_en = 0;
        rdy_mode = 0;
        occ_max = 0;
        send_frame(150, 1);
        repeat (4) @(posedge rx_link_clk);
        check_val(128, occ_max);
        check_val(1, ovf_seen > 0);
        // sink always ready drains faster than the link writes
        rdy_mode = 1;
        unf_seen = 0;
        for (int i = 0; i < 2000 && unf_seen == 0; i++) @(posedge mclk);
        check_val(1, unf_seen > 0);
        results();
    end
endmodule // sgrxeb_top_tb
